// ===== design/pltrc_core.sv
// Purpose: registers and sequencing of the per-lane prbs7 test
// Assumes: one register access per cycle on the index port
// Notes:   results are word index = channel, bit = lane
`timescale 1ns/100ps
module pltrc_core #(
    parameter int MS_CYCLES = pltrc_pkg::MS_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic [2:0]  regSel,
    input  wire logic        regWr,
    input  wire logic        regRd,
    input  wire logic [31:0] regWrData,
    output logic      [31:0] regRdData,
    input  wire logic [31:0] laneRx,
    output logic      [31:0] laneTx
);
    localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

    pltrc_pkg::pltrc_state_t state;
    pltrc_pkg::pltrc_state_t next_state;
    logic [31:0] ctrl;
    logic [31:0] res;
    logic [31:0] mask;
    logic [15:0] msLeft;
    logic [15:0] tick;
    logic [2:0]  phase;
    logic        go;
    logic [31:0] next_ctrl;
    logic [31:0] next_res;
    logic [31:0] next_mask;
    logic [15:0] next_msLeft;
    logic [15:0] next_tick;
    logic        next_go;
    logic [31:0] next_rdData;
    logic [31:0] laneErr;
    logic        running;
    logic        trig;
    logic [15:0] dur;

    // lane n of channel c takes part only with both bits set
    function automatic logic [31:0] laneMask(input logic [31:0] c);
        logic [31:0] m;
        m = '0;
        for (int ch = 0; ch < pltrc_pkg::CHANS; ch++) begin
            for (int ln = 0; ln < pltrc_pkg::LANES; ln++) begin
                m[ch * pltrc_pkg::LANES + ln] =
                    c[pltrc_pkg::SEL_LSB + ch] &
                    c[pltrc_pkg::LEN_LSB + ln];
            end
        end
        return m;
    endfunction

    assign running = (state == pltrc_pkg::ST_RUN);
    assign dur     = ctrl[pltrc_pkg::DUR_LSB +: pltrc_pkg::DUR_W];
    assign trig    = regWr && (regSel == pltrc_pkg::IDX_TRIG) &&
                     regWrData[pltrc_pkg::TRIG_BIT];

    for (genvar i = 0; i < pltrc_pkg::ALL_LANES; i++) begin : g_lane
        pltrc_lane_if lif ();
        assign lif.go     = go;
        assign lif.run    = running & mask[i];
        assign lif.strobe = (phase == pltrc_pkg::SAMPLE_PH);
        assign laneErr[i] = lif.err;
        pltrc_lane u_lane (
            .mclk    (mclk),
            .sys_rst (sys_rst),
            .rxPin   (laneRx[i]),
            .txPin   (laneTx[i]),
            .ctl     (lif)
        );
    end

    // register file
    always_comb begin
        next_ctrl = ctrl;
        if (regWr && regSel == pltrc_pkg::IDX_CTRL) begin
            next_ctrl = regWrData & pltrc_pkg::CTRL_MASK;
        end
        next_rdData = regRdData;
        if (regRd) begin
            next_rdData = '0;
            unique case (regSel)
                pltrc_pkg::IDX_CH0,
                pltrc_pkg::IDX_CH1,
                pltrc_pkg::IDX_CH2,
                pltrc_pkg::IDX_CH3: begin
                    next_rdData = 32'(res[regSel[1:0] *
                                  pltrc_pkg::LANES +: pltrc_pkg::LANES]);
                end
                pltrc_pkg::IDX_CTRL: begin
                    next_rdData = ctrl;
                end
                pltrc_pkg::IDX_STAT: begin
                    next_rdData[pltrc_pkg::STAT_BIT] = running;
                end
                default: begin
                    // trigger self-clears so it always reads zero
                    next_rdData = '0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl      <= pltrc_pkg::CTRL_RST;
            regRdData <= '0;
        end else begin
            ctrl      <= next_ctrl;
            regRdData <= next_rdData;
        end
    end

    // test sequencer; config is snapshotted so writes mid-run are harmless
    always_comb begin
        next_state  = state;
        next_res    = res;
        next_mask   = mask;
        next_msLeft = msLeft;
        next_tick   = tick;
        next_go     = 1'b0;
        unique case (state)
            pltrc_pkg::ST_IDLE: begin
                if (trig) begin
                    next_state  = pltrc_pkg::ST_RUN;
                    next_go     = 1'b1;
                    next_mask   = laneMask(ctrl);
                    next_res    = '0;
                    next_tick   = '0;
                    next_msLeft = (dur == '0) ? pltrc_pkg::DEF_MS
                                              : dur;
                end
            end
            pltrc_pkg::ST_RUN: begin
                // retrigger while running is ignored
                if (tick == MS_LAST) begin
                    next_tick = '0;
                    if (msLeft == 16'h0001) begin
                        next_state = pltrc_pkg::ST_IDLE;
                        next_res   = mask & ~laneErr;
                    end else begin
                        next_msLeft = 16'(msLeft - 16'h0001);
                    end
                end else begin
                    next_tick = 16'(tick + 16'h0001);
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state  <= pltrc_pkg::ST_IDLE;
            res    <= '0;
            mask   <= '0;
            msLeft <= '0;
            tick   <= '0;
            go     <= 1'b0;
            phase  <= '0;
        end else begin
            state  <= next_state;
            res    <= next_res;
            mask   <= next_mask;
            msLeft <= next_msLeft;
            tick   <= next_tick;
            go     <= next_go;
            phase  <= 3'(phase + 3'h1);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence startReq;
        trig && !running;
    endsequence

    sequence lastTick;
        running && tick == MS_LAST && msLeft == 16'h0001;
    endsequence

    trigger_start_a: assert property (
        startReq |=> running && go ##1 !go)
        else $error("trigger did not start one test");

    trigger_reads_zero_a: assert property (
        regRd && regSel == pltrc_pkg::IDX_TRIG |=> regRdData == '0)
        else $error("trigger bit read back nonzero");

    run_status_a: assert property (
        regRd && regSel == pltrc_pkg::IDX_STAT
        |=> regRdData == 32'($past(running)))
        else $error("run status does not match sequencer");

    result_upper_a: assert property (
        regRd && regSel <= pltrc_pkg::IDX_CH3
        |=> regRdData[31:8] == '0)
        else $error("result word upper bits not zero");

    duration_default_a: assert property (
        startReq ##0 dur == '0 |=> msLeft == pltrc_pkg::DEF_MS)
        else $error("zero duration did not give ten ms");

    duration_load_a: assert property (
        startReq ##0 dur != '0 |=> msLeft == $past(dur))
        else $error("duration not loaded from control");

    lane_gate_a: assert property (
        go |-> mask == ({pltrc_pkg::CHANS{ctrl[pltrc_pkg::LEN_LSB +:
                                               pltrc_pkg::LANES]}} &
                        {{pltrc_pkg::LANES{ctrl[pltrc_pkg::SEL_LSB + 3]}},
                         {pltrc_pkg::LANES{ctrl[pltrc_pkg::SEL_LSB + 2]}},
                         {pltrc_pkg::LANES{ctrl[pltrc_pkg::SEL_LSB + 1]}},
                         {pltrc_pkg::LANES{ctrl[pltrc_pkg::SEL_LSB]}}}))
        else $error("tested lanes differ from select and enable");

    result_update_a: assert property (
        lastTick |=> !running && res == $past(mask & ~laneErr))
        else $error("results not updated at end of run");

    unselected_zero_a: assert property (
        !running |-> (res & ~mask) == '0)
        else $error("unselected lane reports pass");

    reset_values_a: assert property (
        $past(sys_rst) |-> ctrl == pltrc_pkg::CTRL_RST && res == '0)
        else $error("control or results wrong after reset");
endmodule

// ===== design/pltrc_pkg.sv
// Purpose: shared constants for the lane integrity test block
// Assumes: 10 MHz mclk, register index port, four channels of eight lanes
// Notes:   register indices are word indices on the control port
package pltrc_pkg;
    localparam int          LANES     = 8;
    localparam int          CHANS     = 4;
    localparam int          ALL_LANES = LANES * CHANS;
    localparam int          REG_W     = 32;
    localparam int          IDX_W     = 3;
    // register indices
    localparam logic [2:0]  IDX_CH0   = 3'h0;
    localparam logic [2:0]  IDX_CH1   = 3'h1;
    localparam logic [2:0]  IDX_CH2   = 3'h2;
    localparam logic [2:0]  IDX_CH3   = 3'h3;
    localparam logic [2:0]  IDX_CTRL  = 3'h4;
    localparam logic [2:0]  IDX_TRIG  = 3'h5;
    localparam logic [2:0]  IDX_STAT  = 3'h6;
    // control word layout
    localparam int          DUR_LSB   = 0;
    localparam int          DUR_W     = 16;
    localparam int          SEL_LSB   = 16;
    localparam int          LEN_LSB   = 20;
    localparam int          TRIG_BIT  = 0;
    localparam int          STAT_BIT  = 0;
    localparam logic [31:0] CTRL_RST  = 32'h0fff0000;
    localparam logic [31:0] CTRL_MASK = 32'h0fffffff;
    localparam logic [31:0] RES_MASK  = 32'h000000ff;
    // timing
    localparam int          CLK_NS    = 100;
    localparam int          MS_NS     = 1000000;
    localparam int          MS_CYCLES = MS_NS / CLK_NS;
    localparam logic [15:0] DEF_MS    = 16'h000a;
    localparam logic [2:0]  SAMPLE_PH = 3'h7;
    localparam logic [3:0]  WARM_BITS = 4'h8;
    localparam logic [6:0]  PRBS_SEED = 7'h7f;
    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } pltrc_state_t;
endpackage

// ===== design/pltrc_lane_if.sv
// Purpose: control and result signals between core and one lane
// Assumes: single mclk domain
// Notes:   one instance per lane
`timescale 1ns/100ps
interface pltrc_lane_if;
    logic go;
    logic run;
    logic strobe;
    logic err;
    modport core (output go, output run, output strobe, input err);
    modport lane (input go, input run, input strobe, output err);
endinterface

// ===== design/pltrc_lane.sv
// Purpose: prbs7 generator and self-synchronising checker for one lane
// Assumes: loopback delay of the far receiver under four mclk cycles
// Notes:   one bit per eight clocks so the pin filter can settle
`timescale 1ns/100ps
module pltrc_lane (
    input  wire logic  mclk,
    input  wire logic  sys_rst,
    input  wire logic  rxPin,
    output logic       txPin,
    pltrc_lane_if.lane ctl
);
    logic [6:0] txSr;
    logic [6:0] chkSr;
    logic [2:0] rxSync;
    logic       rxStable;
    logic [3:0] warm;
    logic       err;
    logic [6:0] next_txSr;
    logic [6:0] next_chkSr;
    logic       next_rxStable;
    logic [3:0] next_warm;
    logic       next_err;
    logic       next_txPin;

    assign ctl.err = err;

    always_comb begin
        next_txSr     = txSr;
        next_chkSr    = chkSr;
        next_warm     = warm;
        next_err      = err;
        next_txPin    = txPin;
        // change counts only once stages two and three agree
        next_rxStable = (rxSync[1] == rxSync[2]) ? rxSync[2] : rxStable;
        if (ctl.go) begin
            next_txSr  = pltrc_pkg::PRBS_SEED;
            next_chkSr = '0;
            next_warm  = '0;
            next_err   = 1'b0;
            next_txPin = 1'b0;
        end else if (ctl.run && ctl.strobe) begin
            // x^7 + x^6 + 1 sequence out and back
            next_txSr  = {txSr[5:0], txSr[6] ^ txSr[5]};
            next_txPin = txSr[6] ^ txSr[5];
            next_chkSr = {chkSr[5:0], rxStable};
            // checker takes eight bits before it starts to predict
            if (warm != pltrc_pkg::WARM_BITS) begin
                next_warm = 4'(warm + 4'h1);
            end else if (rxStable != (chkSr[6] ^ chkSr[5])) begin
                next_err = 1'b1;
            end
        end else if (!ctl.run) begin
            next_txPin = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            txSr     <= '0;
            chkSr    <= '0;
            rxSync   <= '0;
            rxStable <= 1'b0;
            warm     <= '0;
            err      <= 1'b0;
            txPin    <= 1'b0;
        end else begin
            txSr     <= next_txSr;
            chkSr    <= next_chkSr;
            rxSync   <= {rxSync[1:0], rxPin};
            rxStable <= next_rxStable;
            warm     <= next_warm;
            err      <= next_err;
            txPin    <= next_txPin;
        end
    end
endmodule

// ===== verification/pltrc_rx_model.sv
// Purpose: far receiver model that echoes each lane back one mclk late
// Assumes: loopback delay of one mclk, inside the lane timing budget
// Notes:   faultMask flips echoed bits to emulate a broken lane
`timescale 1ns/100ps
module pltrc_rx_model (
    input  wire logic        mclk,
    input  wire logic [31:0] laneTx,
    input  wire logic [31:0] faultMask,
    output logic      [31:0] laneRx
);
    // a real receiver adds delay, so the echo is never combinational
    always_ff @(posedge mclk) begin
        laneRx <= laneTx ^ faultMask;
    end
endmodule

// ===== verification/tb.sv
// Purpose: self-checking bench for the lane integrity test registers
// Assumes: MS_CYCLES shortened to 20 so a millisecond is 20 mclk
// Notes:   status polling adds a few cycles of slack to run lengths
`timescale 1ns/100ps
module tb;
    localparam int MSC = 20;
    logic        mclk      = 1'b0;
    logic        sysRst    = 1'b1;
    logic [2:0]  regSel    = 3'h0;
    logic        regWr     = 1'b0;
    logic        regRd     = 1'b0;
    logic [31:0] regWrData = 32'h0;
    logic [31:0] faultMask = 32'h0;
    logic [31:0] regRdData;
    logic [31:0] laneRx;
    logic [31:0] laneTx;
    logic [31:0] rdv;
    logic [31:0] txSeen    = 32'h0;
    int          errors    = 0;
    int          checked   = 0;
    int          cyc       = 0;
    int          t0        = 0;
    logic [2:0]  rowIdx [8] = '{3'h0, 3'h1, 3'h2, 3'h3,
                                3'h4, 3'h5, 3'h6, 3'h7};
    logic [31:0] rowExp [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0fff0000,
                                32'h0, 32'h0, 32'h0};

    always #50 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;

    pltrc_core #(.MS_CYCLES(MSC)) dut_u (
        .mclk      (mclk),
        .sys_rst   (sysRst),
        .regSel    (regSel),
        .regWr     (regWr),
        .regRd     (regRd),
        .regWrData (regWrData),
        .regRdData (regRdData),
        .laneRx    (laneRx),
        .laneTx    (laneTx)
    );

    pltrc_rx_model rx_u (
        .mclk      (mclk),
        .laneTx    (laneTx),
        .faultMask (faultMask),
        .laneRx    (laneRx)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [2:0] idx, input logic [31:0] d);
        @(posedge mclk);
        #1;
        regWr = 1'b1;
        regSel = idx;
        regWrData = d;
        @(posedge mclk);
        #1;
        regWr = 1'b0;
    endtask

    // one extra edge before sampling, data holds until the next read
    task automatic rd(input logic [2:0] idx, output logic [31:0] d);
        @(posedge mclk);
        #1;
        regRd = 1'b1;
        regSel = idx;
        @(posedge mclk);
        #1;
        regRd = 1'b0;
        @(posedge mclk);
        #1;
        d = regRdData;
    endtask

    task automatic results;
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic start_run;
        wr(pltrc_pkg::IDX_TRIG, 32'h1);
        t0 = cyc;
    endtask

    task automatic wait_idle(input int ms);
        int n;
        int el;
        n = 0;
        rd(pltrc_pkg::IDX_STAT, rdv);
        while (rdv[0] !== 1'b0 && n < 600) begin
            rd(pltrc_pkg::IDX_STAT, rdv);
            n++;
        end
        el = cyc - t0;
        if (n == 600) begin
            errors++;
            $display("ERROR %0t: run never finished", $time);
            results();
        end else begin
            chk(32'(el >= ms * MSC && el <= ms * MSC + 8), 32'h1);
        end
    endtask

    initial begin
        repeat (12) @(posedge mclk);
        #1;
        sysRst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(rowIdx[i], rdv);
            chk(rdv, rowExp[i]);
        end
        wr(pltrc_pkg::IDX_CTRL, 32'hffffffff);
        wr(pltrc_pkg::IDX_CH1, 32'hffffffff);
        rd(pltrc_pkg::IDX_CTRL, rdv);
        chk(rdv, 32'h0fffffff);
        rd(pltrc_pkg::IDX_CH1, rdv);
        chk(rdv, 32'h0);
        // default duration; lane 3 of channel 2 breaks after warm-up
        wr(pltrc_pkg::IDX_CTRL, 32'h0fff0000);
        start_run();
        rd(pltrc_pkg::IDX_STAT, rdv);
        chk(rdv, 32'h1);
        rd(pltrc_pkg::IDX_TRIG, rdv);
        chk(rdv, 32'h0);
        repeat (100) @(posedge mclk);
        #1;
        faultMask = 32'h00080000;
        // a second trigger mid-run must not stretch the run
        wr(pltrc_pkg::IDX_TRIG, 32'h1);
        wait_idle(10);
        faultMask = 32'h0;
        for (int i = 0; i < 4; i++) begin
            rd(3'(i), rdv);
            chk(rdv, (i == 2) ? 32'hf7 : 32'hff);
        end
        // channel 1 off, lane 5 off, fifteen milliseconds
        wr(pltrc_pkg::IDX_CTRL, 32'h0dfd000f);
        start_run();
        // prbs from the seed shows its first one within seven bits
        txSeen = 32'h0;
        repeat (100) begin
            @(posedge mclk);
            #1;
            txSeen = txSeen | laneTx;
        end
        chk(txSeen & 32'h2020ff20, 32'h0);
        chk(txSeen & 32'hdfdf00df, 32'hdfdf00df);
        wait_idle(15);
        chk(laneTx, 32'h0);
        for (int i = 0; i < 4; i++) begin
            rd(3'(i), rdv);
            chk(rdv, (i == 1) ? 32'h0 : 32'hdf);
        end
        // reset in mid-run returns everything to idle defaults
        start_run();
        repeat (20) @(posedge mclk);
        #1;
        sysRst = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        sysRst = 1'b0;
        rd(pltrc_pkg::IDX_STAT, rdv);
        chk(rdv, 32'h0);
        rd(pltrc_pkg::IDX_CTRL, rdv);
        chk(rdv, 32'h0fff0000);
        rd(pltrc_pkg::IDX_CH3, rdv);
        chk(rdv, 32'h0);
        chk(laneTx, 32'h0);
        results();
    end
endmodule
